// >>> pmb_pkg.sv
// ==========================================================================
// Shared constants, register map and helpers for the pulse control core
package pmb_pkg;

  // ========================================================================
  // Bus widths
  localparam int PMB_ADDR_W = 6;
  localparam int PMB_DATA_W = 32;
  localparam int PMB_TIME_W = 32;
  localparam int PMB_CNT_W = 14;
  localparam int PMB_DUTY_W = 7;

  // ========================================================================
  // Register byte offsets
  localparam logic [PMB_ADDR_W-1:0] PMB_OFS_CTRL = 6'h00;
  localparam logic [PMB_ADDR_W-1:0] PMB_OFS_COUNT = 6'h04;
  localparam logic [PMB_ADDR_W-1:0] PMB_OFS_DUTY = 6'h08;
  localparam logic [PMB_ADDR_W-1:0] PMB_OFS_PERIOD = 6'h0C;
  localparam logic [PMB_ADDR_W-1:0] PMB_OFS_WIDTH = 6'h10;
  localparam logic [PMB_ADDR_W-1:0] PMB_OFS_SPACING = 6'h14;
  localparam logic [PMB_ADDR_W-1:0] PMB_OFS_CMD = 6'h18;
  localparam logic [PMB_ADDR_W-1:0] PMB_OFS_STATUS = 6'h1C;
  localparam logic [PMB_ADDR_W-1:0] PMB_OFS_ONTIME = 6'h20;

  // ========================================================================
  // Field positions
  localparam int PMB_CTRL_MODE_LSB = 0;
  localparam int PMB_CTRL_COMP_BIT = 2;
  localparam int PMB_CTRL_DUTY_BIT = 3;
  localparam int PMB_CTRL_PAIR_BIT = 4;
  localparam int PMB_CMD_FIRE_BIT = 0;
  localparam int PMB_ST_BUSY_BIT = 0;
  localparam int PMB_ST_RANGE_BIT = 1;
  localparam int PMB_ST_REJECT_BIT = 2;
  localparam int PMB_ST_REMAIN_LSB = 16;

  // ========================================================================
  // Limits and reset values (times in 10 ps ticks)
  localparam logic [PMB_CNT_W-1:0] PMB_COUNT_MIN = 14'h0001;
  localparam logic [PMB_CNT_W-1:0] PMB_COUNT_MAX = 14'h270F;
  localparam logic [PMB_CNT_W-1:0] PMB_COUNT_RST = 14'h0001;
  localparam logic [PMB_DUTY_W-1:0] PMB_DUTY_MIN = 7'h01;
  localparam logic [PMB_DUTY_W-1:0] PMB_DUTY_MAX = 7'h63;
  localparam logic [PMB_DUTY_W-1:0] PMB_DUTY_RST = 7'h0A;
  localparam logic [PMB_TIME_W-1:0] PMB_PERIOD_RST = 32'h0001_86A0;
  localparam logic [PMB_TIME_W-1:0] PMB_WIDTH_RST = 32'h0000_03E8;
  localparam logic [PMB_TIME_W-1:0] PMB_SPACING_RST = 32'h0131_2D00;
  localparam logic [PMB_DUTY_W:0] PMB_DUTY_DIV_SINGLE = 8'h64;
  localparam logic [PMB_DUTY_W:0] PMB_DUTY_DIV_DOUBLE = 8'hC8;

  // ========================================================================
  // Timing figures and derived tick counts
  localparam int PMB_TICK_PS = 10;
  localparam int PMB_CLK_PERIOD_PS = 4000;
  localparam int PMB_BURST_MIN_PERIOD_PS = 5000;
  localparam int PMB_ONT_KNEE_PS = 1000;
  localparam int PMB_SPACE_OFS_LOW_PS = 1100;
  localparam int PMB_SPACE_OFS_HIGH_PS = 600;
  localparam logic [PMB_TIME_W-1:0] PMB_STEP_TICKS =
    PMB_TIME_W'(PMB_CLK_PERIOD_PS / PMB_TICK_PS);
  localparam logic [PMB_TIME_W-1:0] PMB_BURST_MIN_TICKS =
    PMB_TIME_W'((PMB_BURST_MIN_PERIOD_PS + PMB_TICK_PS - 1) / PMB_TICK_PS);
  localparam logic [PMB_TIME_W-1:0] PMB_ONT_KNEE_TICKS =
    PMB_TIME_W'(PMB_ONT_KNEE_PS / PMB_TICK_PS);
  // Offsets scaled by ten so that the 0.8 factor stays integral
  localparam logic [39:0] PMB_SPACE_OFS_LOW_X10 =
    40'(PMB_SPACE_OFS_LOW_PS);
  localparam logic [39:0] PMB_SPACE_OFS_HIGH_X10 =
    40'(PMB_SPACE_OFS_HIGH_PS);
  localparam logic [3:0] PMB_SCALE_TEN = 4'hA;
  localparam logic [3:0] PMB_SCALE_EIGHT = 4'h8;

  // ========================================================================
  // Operating modes, one-hot
  typedef enum logic [3:0] {
    PMB_MODE_FREE  = 4'h1,
    PMB_MODE_SINGLE = 4'h2,
    PMB_MODE_GATE  = 4'h4,
    PMB_MODE_BURST = 4'h8
  } pmb_mode_t;

  // Register code to mode
  function automatic pmb_mode_t pmb_mode_decode(input logic [1:0] code);
    case (code)
      2'h0: pmb_mode_decode = PMB_MODE_FREE;
      2'h1: pmb_mode_decode = PMB_MODE_SINGLE;
      2'h2: pmb_mode_decode = PMB_MODE_GATE;
      default: pmb_mode_decode = PMB_MODE_BURST;
    endcase
  endfunction

  // Mode to register code
  function automatic logic [1:0] pmb_mode_encode(input pmb_mode_t mode);
    case (mode)
      PMB_MODE_FREE: pmb_mode_encode = 2'h0;
      PMB_MODE_SINGLE: pmb_mode_encode = 2'h1;
      PMB_MODE_GATE: pmb_mode_encode = 2'h2;
      default: pmb_mode_encode = 2'h3;
    endcase
  endfunction

  // On-time from width or from period and duty percentage
  function automatic logic [PMB_TIME_W-1:0] pmb_on_time(
      input logic duty_en, input logic pair_en,
      input logic [PMB_TIME_W-1:0] period,
      input logic [PMB_DUTY_W-1:0] duty,
      input logic [PMB_TIME_W-1:0] width);
    logic [PMB_TIME_W+PMB_DUTY_W-1:0] prod;
    prod = period * duty;
    if (!duty_en)
      pmb_on_time = width;
    else if (pair_en)
      pmb_on_time = PMB_TIME_W'(prod / PMB_DUTY_DIV_DOUBLE);
    else
      pmb_on_time = PMB_TIME_W'(prod / PMB_DUTY_DIV_SINGLE);
  endfunction

  // On-time too long against the second pulse spacing
  function automatic logic pmb_space_bad(
      input logic [PMB_TIME_W-1:0] on_t,
      input logic [PMB_TIME_W-1:0] spacing);
    logic [39:0] on10;
    logic [39:0] lim;
    logic [39:0] ofs;
    on10 = 40'(on_t) * PMB_SCALE_TEN;
    lim = 40'(spacing) * PMB_SCALE_EIGHT;
    ofs = (on_t < PMB_ONT_KNEE_TICKS) ? PMB_SPACE_OFS_LOW_X10 :
          PMB_SPACE_OFS_HIGH_X10;
    pmb_space_bad = (lim < ofs) || (on10 > (lim - ofs));
  endfunction

endpackage

// >>> pmb_shaper.sv
// ==========================================================================
// Period phase accumulator: draws one pulse or a pulse pair per period
module pmb_shaper import pmb_pkg::*; #(
  parameter int TIME_W = PMB_TIME_W
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_go,
  input wire logic [TIME_W-1:0] i_period,
  input wire logic [TIME_W-1:0] i_on_time,
  input wire logic [TIME_W-1:0] i_spacing,
  input wire logic i_double,
  output logic o_wave,
  output logic o_period_end,
  output logic o_active
);

  logic active_ff;
  logic nxt_active;
  logic [TIME_W-1:0] phase_ff;
  logic [TIME_W-1:0] nxt_phase;
  logic wave_ff;
  logic nxt_wave;
  logic [TIME_W:0] phase_step;

  // ========================================================================
  // Next phase, wrap at period end, pulse windows
  always_comb begin
    phase_step = {1'b0, phase_ff} + {1'b0, TIME_W'(PMB_STEP_TICKS)};
    o_period_end = active_ff && (phase_step >= {1'b0, i_period});
    nxt_active = active_ff;
    nxt_phase = phase_ff;
    if (!active_ff) begin
      if (i_go) begin
        nxt_active = 1'b1;
        nxt_phase = '0;
      end
    end else if (o_period_end) begin
      if (i_go) begin
        nxt_phase = TIME_W'(phase_step - {1'b0, i_period});
      end else begin
        nxt_active = 1'b0;
        nxt_phase = '0;
      end
    end else begin
      nxt_phase = phase_step[TIME_W-1:0];
    end
    nxt_wave = nxt_active && ((nxt_phase < i_on_time) ||
               (i_double && (nxt_phase >= i_spacing) &&
                ((nxt_phase - i_spacing) < i_on_time)));
  end

  // State registers
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      active_ff <= 1'b0;
      phase_ff <= '0;
      wave_ff <= 1'b0;
    end else begin
      active_ff <= nxt_active;
      phase_ff <= nxt_phase;
      wave_ff <= nxt_wave;
    end
  end

  assign o_wave = wave_ff;
  assign o_active = active_ff;

endmodule // pmb_shaper

// >>> pmb_core.sv
// ==========================================================================
// Pulse generator control core: mode, burst, polarity and on-time
//
// Strobed register access and the placing of the registers were left to the implementer.
module pmb_core import pmb_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic [PMB_ADDR_W-1:0] i_reg_addr,
  input wire logic [PMB_DATA_W-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [PMB_DATA_W-1:0] o_reg_rdata,
  input wire logic i_external_trigger_input,
  input wire logic i_manual_fire_key,
  input wire logic i_single_shot_key,
  output logic o_pulse_true,
  output logic o_pulse_inv,
  output logic o_busy,
  output logic o_range_err
);

  // ========================================================================
  // Declarations
  pmb_mode_t mode_ff, nxt_mode;
  logic comp_ff, nxt_comp;
  logic duty_en_ff, nxt_duty_en;
  logic pair_en_ff, nxt_pair_en;
  logic [PMB_CNT_W-1:0] count_ff, nxt_count;
  logic [PMB_DUTY_W-1:0] duty_ff, nxt_duty;
  logic [PMB_TIME_W-1:0] period_ff, nxt_period;
  logic [PMB_TIME_W-1:0] width_ff, nxt_width;
  logic [PMB_TIME_W-1:0] spacing_ff, nxt_spacing;
  logic reject_ff, nxt_reject;
  logic [PMB_DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [PMB_CNT_W-1:0] remain_ff, nxt_remain;
  logic ext_prev_ff;
  logic out_true_ff, out_inv_ff;
  logic nxt_out_true;
  logic [PMB_TIME_W-1:0] on_time;
  logic range_bad;
  logic ext_edge, bus_fire, fire_burst, fire_one, idle;
  logic go, period_end, shaper_active, wave;
  pmb_mode_t wr_mode;
  logic wr_duty_en, ctrl_ok, bad_wr;
  logic [PMB_CNT_W-1:0] wr_count;
  logic [PMB_DUTY_W-1:0] wr_duty;

  // ========================================================================
  // On-time and spacing check
  always_comb begin
    on_time = pmb_on_time(duty_en_ff, pair_en_ff, period_ff, duty_ff,
                          width_ff);
    range_bad = pair_en_ff && pmb_space_bad(on_time, spacing_ff);
  end

  // ========================================================================
  // Register writes with legality checks
  always_comb begin
    wr_mode = pmb_mode_decode(i_reg_wdata[PMB_CTRL_MODE_LSB +: 2]);
    wr_duty_en = i_reg_wdata[PMB_CTRL_DUTY_BIT];
    wr_count = i_reg_wdata[PMB_CNT_W-1:0];
    wr_duty = i_reg_wdata[PMB_DUTY_W-1:0];
    ctrl_ok = !((wr_mode == PMB_MODE_BURST) &&
                (period_ff < PMB_BURST_MIN_TICKS)) &&
              !(wr_duty_en && (wr_mode == PMB_MODE_SINGLE));
    nxt_mode = mode_ff;
    nxt_comp = comp_ff;
    nxt_duty_en = duty_en_ff;
    nxt_pair_en = pair_en_ff;
    nxt_count = count_ff;
    nxt_duty = duty_ff;
    nxt_period = period_ff;
    nxt_width = width_ff;
    nxt_spacing = spacing_ff;
    bad_wr = 1'b0;
    if (i_reg_wr) begin
      case (i_reg_addr)
        PMB_OFS_CTRL: begin
          if (ctrl_ok) begin
            nxt_mode = wr_mode;
            nxt_comp = i_reg_wdata[PMB_CTRL_COMP_BIT];
            nxt_duty_en = wr_duty_en;
            nxt_pair_en = i_reg_wdata[PMB_CTRL_PAIR_BIT];
          end else begin
            bad_wr = 1'b1;
          end
        end
        PMB_OFS_COUNT: begin
          if ((i_reg_wdata <= PMB_DATA_W'(PMB_COUNT_MAX)) &&
              (wr_count >= PMB_COUNT_MIN)) begin
            nxt_count = wr_count;
          end else begin
            bad_wr = 1'b1;
          end
        end
        PMB_OFS_DUTY: begin
          if ((i_reg_wdata <= PMB_DATA_W'(PMB_DUTY_MAX)) &&
              (wr_duty >= PMB_DUTY_MIN)) begin
            nxt_duty = wr_duty;
          end else begin
            bad_wr = 1'b1;
          end
        end
        PMB_OFS_PERIOD: begin
          if ((mode_ff == PMB_MODE_BURST) &&
              (i_reg_wdata < PMB_BURST_MIN_TICKS)) begin
            bad_wr = 1'b1;
          end else begin
            nxt_period = i_reg_wdata;
          end
        end
        PMB_OFS_WIDTH: nxt_width = i_reg_wdata;
        PMB_OFS_SPACING: nxt_spacing = i_reg_wdata;
        default: ;
      endcase
    end
    // Refused writes set the sticky flag; a new refusal beats the clear
    nxt_reject = reject_ff;
    if (i_reg_wr && (i_reg_addr == PMB_OFS_STATUS) &&
        i_reg_wdata[PMB_ST_REJECT_BIT]) begin
      nxt_reject = 1'b0;
    end
    if (bad_wr) begin
      nxt_reject = 1'b1;
    end
  end

  // ========================================================================
  // Read data, valid only in the cycle after the strobe
  always_comb begin
    nxt_rdata = '0;
    if (i_reg_rd) begin
      case (i_reg_addr)
        PMB_OFS_CTRL: begin
          nxt_rdata[PMB_CTRL_MODE_LSB +: 2] = pmb_mode_encode(mode_ff);
          nxt_rdata[PMB_CTRL_COMP_BIT] = comp_ff;
          nxt_rdata[PMB_CTRL_DUTY_BIT] = duty_en_ff;
          nxt_rdata[PMB_CTRL_PAIR_BIT] = pair_en_ff;
        end
        PMB_OFS_COUNT: nxt_rdata[PMB_CNT_W-1:0] = count_ff;
        PMB_OFS_DUTY: nxt_rdata[PMB_DUTY_W-1:0] = duty_ff;
        PMB_OFS_PERIOD: nxt_rdata = period_ff;
        PMB_OFS_WIDTH: nxt_rdata = width_ff;
        PMB_OFS_SPACING: nxt_rdata = spacing_ff;
        PMB_OFS_STATUS: begin
          nxt_rdata[PMB_ST_BUSY_BIT] = !idle;
          nxt_rdata[PMB_ST_RANGE_BIT] = range_bad;
          nxt_rdata[PMB_ST_REJECT_BIT] = reject_ff;
          nxt_rdata[PMB_ST_REMAIN_LSB +: PMB_CNT_W] = remain_ff;
        end
        PMB_OFS_ONTIME: nxt_rdata = on_time;
        default: nxt_rdata = '0;
      endcase
    end
  end

  // Register file storage
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_ff <= PMB_MODE_FREE;
      comp_ff <= 1'b0;
      duty_en_ff <= 1'b0;
      pair_en_ff <= 1'b0;
      count_ff <= PMB_COUNT_RST;
      duty_ff <= PMB_DUTY_RST;
      period_ff <= PMB_PERIOD_RST;
      width_ff <= PMB_WIDTH_RST;
      spacing_ff <= PMB_SPACING_RST;
      reject_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      mode_ff <= nxt_mode;
      comp_ff <= nxt_comp;
      duty_en_ff <= nxt_duty_en;
      pair_en_ff <= nxt_pair_en;
      count_ff <= nxt_count;
      duty_ff <= nxt_duty;
      period_ff <= nxt_period;
      width_ff <= nxt_width;
      spacing_ff <= nxt_spacing;
      reject_ff <= nxt_reject;
      rdata_ff <= nxt_rdata;
    end
  end

  // ========================================================================
  // Trigger sources and pulse sequencing
  always_comb begin
    ext_edge = i_external_trigger_input && !ext_prev_ff;
    bus_fire = i_reg_wr && (i_reg_addr == PMB_OFS_CMD) &&
               i_reg_wdata[PMB_CMD_FIRE_BIT];
    idle = (remain_ff == '0) && !shaper_active;
    fire_burst = (mode_ff == PMB_MODE_BURST) &&
                 (ext_edge || i_manual_fire_key || bus_fire);
    fire_one = (mode_ff != PMB_MODE_FREE) &&
               (i_single_shot_key ||
                ((mode_ff == PMB_MODE_SINGLE) && ext_edge));
    nxt_remain = remain_ff;
    if (period_end && (remain_ff != '0)) begin
      nxt_remain = remain_ff - 1'b1;
    end
    if (idle && fire_burst) begin
      nxt_remain = count_ff;
    end else if (idle && fire_one) begin
      nxt_remain = PMB_COUNT_MIN;
    end
    if (mode_ff == PMB_MODE_FREE) begin
      nxt_remain = '0;
    end
    go = (mode_ff == PMB_MODE_FREE) ||
         ((mode_ff == PMB_MODE_GATE) && i_external_trigger_input) ||
         ((remain_ff != '0) &&
          !(period_end && (remain_ff == PMB_COUNT_MIN)));
    nxt_out_true = wave ^ comp_ff;
  end

  // Sequencer and output registers
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      remain_ff <= '0;
      ext_prev_ff <= 1'b0;
      out_true_ff <= 1'b0;
      out_inv_ff <= 1'b1;
    end else begin
      remain_ff <= nxt_remain;
      ext_prev_ff <= i_external_trigger_input;
      out_true_ff <= nxt_out_true;
      out_inv_ff <= !nxt_out_true;
    end
  end

  // Period timing engine
  pmb_shaper #(
    .TIME_W(PMB_TIME_W)
  ) u_shaper (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_go(go),
    .i_period(period_ff),
    .i_on_time(on_time),
    .i_spacing(spacing_ff),
    .i_double(pair_en_ff),
    .o_wave(wave),
    .o_period_end(period_end),
    .o_active(shaper_active)
  );

  assign o_reg_rdata = rdata_ff;
  assign o_pulse_true = out_true_ff;
  assign o_pulse_inv = out_inv_ff;
  assign o_busy = !idle;
  assign o_range_err = range_bad;

  // ========================================================================
  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  sequence seq_burst_start;
    (mode_ff == PMB_MODE_BURST) && idle && fire_burst;
  endsequence

  sequence seq_burst_loaded;
    remain_ff == $past(count_ff);
  endsequence

  chk_free_runs: assert property (
    (mode_ff == PMB_MODE_FREE) |-> go ##1 shaper_active)
    else $error("free-running mode stopped pulsing");

  chk_free_ignore: assert property (
    (mode_ff == PMB_MODE_FREE) |=> (remain_ff == '0))
    else $error("trigger counted in free-running mode");

  chk_burst_load: assert property (
    seq_burst_start |=> seq_burst_loaded)
    else $error("burst count not loaded on trigger");

  chk_burst_refuse: assert property (
    (mode_ff == PMB_MODE_BURST) |-> (period_ff >= PMB_BURST_MIN_TICKS))
    else $error("burst mode with period below minimum");

  chk_count_range: assert property (
    (count_ff >= PMB_COUNT_MIN) && (count_ff <= PMB_COUNT_MAX))
    else $error("burst count out of range");

  chk_comp_out: assert property (
    ##1 (o_pulse_true == ($past(wave) ^ $past(comp_ff))))
    else $error("true output polarity wrong");

  chk_inv_out: assert property (
    o_pulse_inv == !o_pulse_true)
    else $error("inverted output not opposite of true output");

  chk_duty_range: assert property (
    (duty_ff >= PMB_DUTY_MIN) && (duty_ff <= PMB_DUTY_MAX))
    else $error("duty percentage out of range");

  chk_width_src: assert property (
    !duty_en_ff |-> (on_time == width_ff))
    else $error("on-time not taken from width");

  chk_duty_single: assert property (
    !(duty_en_ff && (mode_ff == PMB_MODE_SINGLE)))
    else $error("duty control active in single event mode");

  chk_mode_onehot: assert property (
    $onehot(mode_ff))
    else $error("operating mode not one-hot");

  chk_burst_busy: assert property (
    (!idle && (remain_ff != '0) && fire_burst && !period_end) |=>
      (remain_ff == $past(remain_ff)))
    else $error("burst retriggered while running");

endmodule // pmb_core

// >>> pmb_far_end.sv
// ========
// Trigger source and load model
module pmb_far_end (
  input wire logic i_core_clk,
  input wire logic i_pulse_true,
  output logic o_ext_trigger
);
  timeunit 1ns;
  timeprecision 100ps;
  int edges;
  logic last_ff;
  // Idle trigger line rests low
  initial begin
    o_ext_trigger = 1'b0;
    edges = 0;
    last_ff = 1'b0;
  end
  // Load counts rising edges of the true output
  always @(posedge i_core_clk) begin
    if (i_pulse_true === 1'b1 && last_ff === 1'b0) begin
      edges <= edges + 1;
    end
    last_ff <= i_pulse_true;
  end
  // One trigger edge, held high two cycles
  task automatic fire();
    @(posedge i_core_clk);
    o_ext_trigger <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    o_ext_trigger <= 1'b0;
  endtask
endmodule // pmb_far_end

// >>> pulse_mode_burst_duty_control_tb_top.sv
// ========
// Self-checking bench for the pulse control core
module pulse_mode_burst_duty_control_tb_top import pmb_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, arst_n, bwr, brd, ext_trigger, fire_key, shot;
  logic ptrue, pinv, busy, rerr;
  logic [5:0] addr;
  logic [31:0] wdata, rdata;
  int error_cnt, compares;

  pmb_core i_dut (.i_core_clk(clk), .i_arst_n(arst_n),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(bwr),
    .i_reg_rd(brd), .o_reg_rdata(rdata),
    .i_external_trigger_input(ext_trigger), .i_manual_fire_key(fire_key),
    .i_single_shot_key(shot), .o_pulse_true(ptrue),
    .o_pulse_inv(pinv), .o_busy(busy), .o_range_err(rerr));
  pmb_far_end i_far (.i_core_clk(clk), .i_pulse_true(ptrue),
    .o_ext_trigger(ext_trigger));

  // ========
  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Register result compare
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  // Pin result compare
  task automatic chk_pin(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t pin got %b exp %b", $time, got, exp);
    end
  endtask
  // Bus write
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    bwr <= 1'b1;
    @(posedge clk);
    bwr <= 1'b0;
  endtask
  // Bus read and compare
  task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    brd <= 1'b1;
    @(posedge clk);
    brd <= 1'b0;
    #1 chk_reg(rdata, exp);
  endtask
  // Wait for a sequence to end, then let output settle
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    repeat (6) @(posedge clk);
  endtask

  // ========
  // Scenarios
  task automatic t_free();
    int e0;
    e0 = i_far.edges;
    i_far.fire();
    repeat (800) @(posedge clk);
    chk_pin(i_far.edges - e0 >= 3, 1'b1);
    rchk(PMB_OFS_STATUS, 32'h0000_0001);
  endtask
  task automatic t_pol();
    wr(PMB_OFS_CTRL, 32'h2);
    repeat (4) @(posedge clk);
    chk_pin(ptrue, 1'b0);
    chk_pin(pinv, 1'b1);
    wr(PMB_OFS_CTRL, 32'h6);
    repeat (4) @(posedge clk);
    chk_pin(ptrue, 1'b1);
    chk_pin(pinv, 1'b0);
    wr(PMB_OFS_CTRL, 32'h0);
  endtask
  task automatic t_ontime();
    wr(PMB_OFS_DUTY, 32'h25);
    wr(PMB_OFS_CTRL, 32'h8);
    rchk(PMB_OFS_ONTIME, 32'h9088);
    wr(PMB_OFS_CTRL, 32'h18);
    rchk(PMB_OFS_ONTIME, 32'h4844);
    wr(PMB_OFS_CTRL, 32'h0);
    rchk(PMB_OFS_ONTIME, 32'h3E8);
  endtask
  task automatic t_range();
    logic [31:0] w[4] = '{32'h3E8, 32'h3E8, 32'h5A, 32'h5A};
    logic [31:0] s[4] = '{32'h52D, 32'h52C, 32'hFA, 32'hF9};
    wr(PMB_OFS_CTRL, 32'h10);
    for (int i = 0; i < 4; i++) begin
      wr(PMB_OFS_WIDTH, w[i]);
      wr(PMB_OFS_SPACING, s[i]);
      #1 chk_pin(rerr, i[0]);
    end
    wr(PMB_OFS_CTRL, 32'h0);
  endtask
  task automatic t_refuse();
    wr(PMB_OFS_COUNT, 32'h0);
    wr(PMB_OFS_COUNT, 32'h2710);
    rchk(PMB_OFS_COUNT, 32'h1);
    wr(PMB_OFS_COUNT, 32'h270F);
    rchk(PMB_OFS_COUNT, 32'h270F);
    wr(PMB_OFS_DUTY, 32'h0);
    wr(PMB_OFS_DUTY, 32'h64);
    rchk(PMB_OFS_DUTY, 32'h25);
    wr(PMB_OFS_DUTY, 32'h63);
    rchk(PMB_OFS_DUTY, 32'h63);
    wr(PMB_OFS_CTRL, 32'h9);
    rchk(PMB_OFS_CTRL, 32'h0);
    wr(PMB_OFS_PERIOD, 32'h1F3);
    wr(PMB_OFS_CTRL, 32'h3);
    rchk(PMB_OFS_CTRL, 32'h0);
    wr(PMB_OFS_PERIOD, 32'h1F4);
    wr(PMB_OFS_CTRL, 32'h3);
    rchk(PMB_OFS_CTRL, 32'h3);
    wr(PMB_OFS_PERIOD, 32'h1F3);
    rchk(PMB_OFS_PERIOD, 32'h1F4);
    rchk(PMB_OFS_STATUS, 32'h4);
    wr(PMB_OFS_STATUS, 32'h4);
    rchk(PMB_OFS_STATUS, 32'h0);
  endtask
  task automatic t_burst();
    int e0;
    wr(PMB_OFS_PERIOD, 32'hFA0);
    wr(PMB_OFS_WIDTH, 32'h4B0);
    wr(PMB_OFS_COUNT, 32'h3);
    for (int src = 0; src < 3; src++) begin
      e0 = i_far.edges;
      if (src == 0) begin
        i_far.fire();
      end else if (src == 1) begin
        @(posedge clk);
        fire_key <= 1'b1;
        @(posedge clk);
        fire_key <= 1'b0;
      end else begin
        wr(PMB_OFS_CMD, 32'h1);
      end
      repeat (5) @(posedge clk);
      chk_pin(busy, 1'b1);
      i_far.fire();
      wait_idle();
      chk_pin(busy, 1'b0);
      chk_reg(i_far.edges - e0, 32'h3);
    end
  endtask
  task automatic t_shot();
    int e0;
    for (int m = 1; m < 4; m++) begin
      wr(PMB_OFS_CTRL, 32'(m));
      e0 = i_far.edges;
      @(posedge clk);
      shot <= 1'b1;
      @(posedge clk);
      shot <= 1'b0;
      wait_idle();
      chk_reg(i_far.edges - e0, 32'h1);
    end
  endtask

  // End of run verdict
  task automatic report_and_stop();
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (50000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    error_cnt = 0;
    compares = 0;
    {arst_n, bwr, brd, fire_key, shot} = '0;
    addr = '0;
    wdata = '0;
    repeat (12) @(posedge clk);
    chk_pin(pinv, 1'b1);
    arst_n <= 1'b1;
    rchk(PMB_OFS_CTRL, 32'h0);
    rchk(PMB_OFS_COUNT, 32'h1);
    rchk(PMB_OFS_DUTY, 32'h0A);
    t_free();
    t_pol();
    t_ontime();
    t_range();
    t_refuse();
    t_burst();
    t_shot();
    report_and_stop();
  end
endmodule // pulse_mode_burst_duty_control_tb_top
